/* core/rcc_config.sv */
`timescale 1ns/100ps
`default_nettype none
module rcc_config #(
  parameter int unsigned INTERVAL_LONG_CYC = rcc_pkg::INTERVAL_LONG_CYC,
  parameter int unsigned INTERVAL_SHORT_CYC = rcc_pkg::INTERVAL_SHORT_CYC,
  parameter logic [127:0] FACTORY_KEY =
    128'h0123_4567_89ab_cdef_0123_4567_89ab_cdef,
  parameter logic [47:0] FACTORY_ADDR = 48'h0000_0000_0001,
  // Arbitrary manufacturer value
  parameter logic [15:0] FACTORY_MAN_ID = 16'h0001,
  parameter logic [31:0] FACTORY_PIN = 32'h0000_0000
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cust_sel_i,
  input wire logic protected_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_ack_o,
  input wire logic factory_reset_i,
  input wire logic key_load_i,
  input wire logic [127:0] key_new_i,
  input wire logic addr_load_i,
  input wire logic [47:0] addr_new_i,
  input wire logic man_load_i,
  input wire logic [15:0] man_new_i,
  input wire logic pin_load_i,
  input wire logic [31:0] pin_new_i,
  output logic [127:0] key_o,
  output logic [47:0] source_addr_o,
  output logic [15:0] man_id_o,
  output logic [31:0] pin_o,
  output logic adv_commission_o,
  output logic adv_data_o,
  output logic [1:0] chan_count_o,
  output logic [7:0] chan_code0_o,
  output logic [7:0] chan_code1_o,
  output logic [7:0] chan_code2_o,
  output logic [11:0] freq0_mhz_o,
  output logic [11:0] freq1_mhz_o,
  output logic [11:0] freq2_mhz_o,
  output logic [31:0] interval_cyc_o,
  output logic rate_2m_o
);
  logic [7:0] variant_r;
  logic [7:0] chan_r [3];
  logic [7:0] cust_mem [rcc_pkg::CUST_BYTES];
  logic [127:0] key_r;
  logic [47:0] addr_r;
  logic [15:0] man_r;
  logic [31:0] pin_r;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic ack_r;

  // Channel number to frequency in MHz
  function automatic logic [11:0] chan_freq(input logic [7:0] c);
    logic [11:0] f;
    f = rcc_pkg::FREQ_BASE_MHZ;
    if (c == rcc_pkg::ADV_CH0) begin
      f = rcc_pkg::FREQ_BASE_MHZ;
    end else if (c == rcc_pkg::ADV_CH1) begin
      f = rcc_pkg::FREQ_ADV1_MHZ;
    end else if (c == rcc_pkg::ADV_CH2) begin
      f = rcc_pkg::FREQ_ADV2_MHZ;
    end else if (c <= rcc_pkg::DATA_LOW_LAST) begin
      f = 12'(rcc_pkg::FREQ_BASE_MHZ + 12'({c, 1'b0}) + 12'h002);
    end else if (c < rcc_pkg::ADV_CH0) begin
      f = 12'(rcc_pkg::FREQ_BASE_MHZ + 12'({c, 1'b0}) + 12'h004);
    end else if (c <= rcc_pkg::CUSTOM_LAST) begin
      f = 12'(rcc_pkg::FREQ_CUSTOM_BASE_MHZ +
        12'({8'(c - rcc_pkg::CUSTOM_FIRST), 1'b0}));
    end
    return f;
  endfunction

  wire logic hit_var = cfg_addr_i == rcc_pkg::ADDR_VARIANT;
  wire logic hit_c1 = cfg_addr_i == rcc_pkg::ADDR_CHAN1;
  wire logic hit_c2 = cfg_addr_i == rcc_pkg::ADDR_CHAN2;
  wire logic hit_c3 = cfg_addr_i == rcc_pkg::ADDR_CHAN3;
  wire logic cust_ok = cust_sel_i && protected_i;
  wire logic cfg_wr = cfg_wr_i && !cust_sel_i;
  wire logic [2:0] mode = variant_r[2:0];
  wire logic wr_var = cfg_wr && hit_var;
  wire logic wr_c1 = cfg_wr && hit_c1;
  wire logic wr_c2 = cfg_wr && hit_c2;
  wire logic wr_c3 = cfg_wr && hit_c3;

  // Reserved bits dropped on write
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      variant_r <= rcc_pkg::VARIANT_RST;
    end else if (wr_var) begin
      variant_r <= cfg_wdata_i & rcc_pkg::VARIANT_MASK;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chan_r[0] <= rcc_pkg::CHAN_RST;
    end else if (wr_c1) begin
      chan_r[0] <= cfg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chan_r[1] <= rcc_pkg::CHAN_RST;
    end else if (wr_c2) begin
      chan_r[1] <= cfg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chan_r[2] <= rcc_pkg::CHAN_RST;
    end else if (wr_c3) begin
      chan_r[2] <= cfg_wdata_i;
    end
  end

  // Customer area has no reset, survives factory reset
  always_ff @(posedge mclk_i) begin
    if (cfg_wr_i && cust_ok) begin
      cust_mem[cfg_addr_i] <= cfg_wdata_i;
    end
  end

  // Private store; factory reset restores backups
  always_ff @(posedge mclk_i) begin
    if (rst_i || factory_reset_i) begin
      key_r <= FACTORY_KEY;
    end else if (key_load_i) begin
      key_r <= key_new_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || factory_reset_i) begin
      addr_r <= FACTORY_ADDR;
    end else if (addr_load_i) begin
      addr_r <= addr_new_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || factory_reset_i) begin
      man_r <= FACTORY_MAN_ID;
    end else if (man_load_i) begin
      man_r <= man_new_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || factory_reset_i) begin
      pin_r <= FACTORY_PIN;
    end else if (pin_load_i) begin
      pin_r <= pin_new_i;
    end
  end

  // Read mux; private data never appears here
  always_comb begin
    rdata_nxt = 8'h00;
    if (cust_sel_i) begin
      if (cust_ok) rdata_nxt = cust_mem[cfg_addr_i];
    end else if (hit_var) begin
      rdata_nxt = variant_r;
    end else if (hit_c1) begin
      rdata_nxt = chan_r[0];
    end else if (hit_c2) begin
      rdata_nxt = chan_r[1];
    end else if (hit_c3) begin
      rdata_nxt = chan_r[2];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (cfg_rd_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cfg_rd_i || cfg_wr_i;
    end
  end

  // Transmission plan decode
  logic adv_com;
  logic adv_dat;
  logic [1:0] cnt;
  always_comb begin
    adv_com = 1'b1;
    adv_dat = 1'b1;
    cnt = 2'h0;
    case (mode)
      rcc_pkg::MODE_STD: begin
        adv_com = 1'b1;
        adv_dat = 1'b1;
        cnt = 2'h0;
      end
      rcc_pkg::MODE_D3: begin
        adv_com = 1'b1;
        adv_dat = 1'b0;
        cnt = 2'h3;
      end
      rcc_pkg::MODE_D2: begin
        adv_com = 1'b1;
        adv_dat = 1'b0;
        cnt = 2'h2;
      end
      rcc_pkg::MODE_D1: begin
        adv_com = 1'b1;
        adv_dat = 1'b0;
        cnt = 2'h1;
      end
      rcc_pkg::MODE_B3: begin
        adv_com = 1'b0;
        adv_dat = 1'b0;
        cnt = 2'h3;
      end
      rcc_pkg::MODE_B2: begin
        adv_com = 1'b0;
        adv_dat = 1'b0;
        cnt = 2'h2;
      end
      rcc_pkg::MODE_B1: begin
        adv_com = 1'b0;
        adv_dat = 1'b0;
        cnt = 2'h1;
      end
      default: begin
        // Reserved code falls back to standard
        adv_com = 1'b1;
        adv_dat = 1'b1;
        cnt = 2'h0;
      end
    endcase
  end

  // Lowest registers fill first; unused slots show code zero
  wire logic use0 = cnt != 2'h0;
  wire logic use1 = cnt >= 2'h2;
  wire logic use2 = cnt == 2'h3;
  wire logic [7:0] c0 = use0 ? chan_r[0] : 8'h00;
  wire logic [7:0] c1 = use1 ? chan_r[1] : 8'h00;
  wire logic [7:0] c2 = use2 ? chan_r[2] : 8'h00;
  wire logic [11:0] f0 = chan_freq(c0);
  wire logic [11:0] f1 = chan_freq(c1);
  wire logic [11:0] f2 = chan_freq(c2);
  wire logic int_short = variant_r[rcc_pkg::INTERVAL_BIT];
  wire logic [31:0] int_cyc = int_short ? INTERVAL_SHORT_CYC :
    INTERVAL_LONG_CYC;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      adv_commission_o <= 1'b1;
      adv_data_o <= 1'b1;
      chan_count_o <= 2'h0;
    end else begin
      adv_commission_o <= adv_com;
      adv_data_o <= adv_dat;
      chan_count_o <= cnt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chan_code0_o <= 8'h00;
      chan_code1_o <= 8'h00;
      chan_code2_o <= 8'h00;
    end else begin
      chan_code0_o <= c0;
      chan_code1_o <= c1;
      chan_code2_o <= c2;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      freq0_mhz_o <= rcc_pkg::FREQ_BASE_MHZ;
      freq1_mhz_o <= rcc_pkg::FREQ_BASE_MHZ;
      freq2_mhz_o <= rcc_pkg::FREQ_BASE_MHZ;
    end else begin
      freq0_mhz_o <= f0;
      freq1_mhz_o <= f1;
      freq2_mhz_o <= f2;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      interval_cyc_o <= INTERVAL_LONG_CYC;
    end else begin
      interval_cyc_o <= int_cyc;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rate_2m_o <= 1'b0;
    end else begin
      rate_2m_o <= variant_r[rcc_pkg::RATE_BIT];
    end
  end

  assign cfg_rdata_o = rdata_r;
  assign cfg_ack_o = ack_r;
  assign key_o = key_r;
  assign source_addr_o = addr_r;
  assign man_id_o = man_r;
  assign pin_o = pin_r;
endmodule
`default_nettype wire

/* core/rcc_pkg.sv */
package rcc_pkg;
  // Variant register layout
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned INTERVAL_BIT = 3;
  localparam int unsigned RATE_BIT = 4;
  localparam logic [7:0] VARIANT_MASK = 8'h1f;
  localparam logic [7:0] VARIANT_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  // Page addresses on the configuration port
  localparam logic [7:0] ADDR_VARIANT = 8'h00;
  localparam logic [7:0] ADDR_CHAN1 = 8'h01;
  localparam logic [7:0] ADDR_CHAN2 = 8'h02;
  localparam logic [7:0] ADDR_CHAN3 = 8'h03;
  localparam int unsigned CUST_PAGES = 64;
  localparam int unsigned CUST_BYTES = 256;
  localparam int unsigned KEY_W = 128;
  // Mode codes
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_D3 = 3'h1;
  localparam logic [2:0] MODE_D2 = 3'h2;
  localparam logic [2:0] MODE_D1 = 3'h3;
  localparam logic [2:0] MODE_B3 = 3'h4;
  localparam logic [2:0] MODE_B2 = 3'h5;
  localparam logic [2:0] MODE_B1 = 3'h6;
  localparam logic [2:0] MODE_RFU = 3'h7;
  // Interval timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned INTERVAL_LONG_MS = 20;
  localparam int unsigned INTERVAL_SHORT_MS = 10;
  localparam int unsigned INTERVAL_LONG_CYC = INTERVAL_LONG_MS * 1000 * CLK_MHZ;
  localparam int unsigned INTERVAL_SHORT_CYC =
    INTERVAL_SHORT_MS * 1000 * CLK_MHZ;
  // Channel map
  localparam logic [7:0] ADV_CH0 = 8'h25;
  localparam logic [7:0] ADV_CH1 = 8'h26;
  localparam logic [7:0] ADV_CH2 = 8'h27;
  localparam logic [7:0] DATA_LOW_LAST = 8'h0a;
  localparam logic [7:0] CUSTOM_FIRST = 8'h28;
  localparam logic [7:0] CUSTOM_LAST = 8'h4e;
  localparam logic [11:0] FREQ_BASE_MHZ = 12'h962;
  localparam logic [11:0] FREQ_ADV1_MHZ = 12'h97a;
  localparam logic [11:0] FREQ_ADV2_MHZ = 12'h9b0;
  localparam logic [11:0] FREQ_CUSTOM_BASE_MHZ = 12'h963;
endpackage

/* dv/rcc_tool.sv */
`timescale 1ns/100ps
`default_nettype none
module rcc_tool (
  input wire logic [31:0] pin_i,
  input wire logic [31:0] try_i,
  output logic unlock_o
);
  // Tool unlocks only with the current PIN
  assign unlock_o = (try_i === pin_i);
endmodule
`default_nettype wire

/* dv/rcc_config_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module rcc_config_checker #(
  parameter int unsigned INTERVAL_LONG_CYC = 20,
  parameter int unsigned INTERVAL_SHORT_CYC = 10,
  parameter logic [127:0] FACTORY_KEY = 128'h0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cust_sel_i,
  input wire logic protected_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic cfg_ack_o,
  input wire logic factory_reset_i,
  input wire logic [127:0] key_o,
  input wire logic adv_commission_o,
  input wire logic adv_data_o,
  input wire logic [1:0] chan_count_o,
  input wire logic [7:0] chan_code0_o,
  input wire logic [11:0] freq0_mhz_o,
  input wire logic [31:0] interval_cyc_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (
    (cfg_wr_i || cfg_rd_i) |=> cfg_ack_o)
    else $error("ack missing");
  ack_quiet_a: assert property (
    !cfg_wr_i && !cfg_rd_i |=> !cfg_ack_o)
    else $error("ack without access");
  std_adv_a: assert property (
    chan_count_o == 2'h0 |-> adv_commission_o && adv_data_o)
    else $error("mode zero not advertising");
  adv_user_a: assert property (
    !adv_commission_o |-> !adv_data_o && chan_count_o != 2'h0)
    else $error("commission off but data on");
  interval_a: assert property (
    cfg_wr_i && !cust_sel_i && cfg_addr_i == 8'h00
    |=> ##1 interval_cyc_o == ($past(cfg_wdata_i[3], 2) ?
    INTERVAL_SHORT_CYC : INTERVAL_LONG_CYC)) else $error("interval wrong");
  cust_lock_a: assert property (
    cfg_rd_i && cust_sel_i && !protected_i
    |=> cfg_rdata_o == 8'h00) else $error("locked read leaked");
  rsvd_zero_a: assert property (
    cfg_rd_i && !cust_sel_i && cfg_addr_i == 8'h00
    |=> cfg_rdata_o[7:5] == 3'h0) else $error("reserved bits set");
  factory_a: assert property (
    factory_reset_i |=> key_o == FACTORY_KEY)
    else $error("key not restored");
  adv_freq_a: assert property (
    chan_code0_o == 8'h25 |-> freq0_mhz_o == 12'h962)
    else $error("advertising frequency wrong");
  cover property (cfg_rd_i && cust_sel_i && protected_i);
  cover property (factory_reset_i);
  cover property (chan_count_o == 2'h3);
endmodule
bind rcc_config rcc_config_checker #(.INTERVAL_LONG_CYC(INTERVAL_LONG_CYC),
  .INTERVAL_SHORT_CYC(INTERVAL_SHORT_CYC), .FACTORY_KEY(FACTORY_KEY))
  rcc_config_checker_i (.*);
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // Factory values are arbitrary
  localparam logic [127:0] FKEY = 128'h00aa;
  localparam logic [31:0] FPIN = 32'h1234;
  logic mclk_i = 0, rst_i = 1, cfg_wr_i = 0, cfg_rd_i = 0, cust_sel_i = 0;
  logic factory_reset_i = 0, key_load_i = 0, addr_load_i = 0;
  logic man_load_i = 0, pin_load_i = 0, cfg_ack_o, rate_2m_o;
  logic adv_commission_o, adv_data_o, protected_i;
  logic [7:0] cfg_addr_i = 0, cfg_wdata_i = 0, cfg_rdata_o, rdq;
  logic [7:0] chan_code0_o, chan_code1_o, chan_code2_o;
  logic [127:0] key_new_i = 128'h5555, key_o;
  logic [47:0] addr_new_i = 48'h0002, source_addr_o;
  logic [15:0] man_new_i = 16'h0003, man_id_o;
  logic [31:0] pin_new_i = 32'h0004, pin_o, try_pin = 0, interval_cyc_o;
  logic [11:0] freq0_mhz_o, freq1_mhz_o, freq2_mhz_o;
  logic [1:0] chan_count_o;
  logic [7:0] codes [9] = '{0, 10, 11, 36, 37, 38, 39, 40, 78};
  int mismatches = 0, tests_run = 0;
  rcc_config #(.INTERVAL_LONG_CYC(20), .INTERVAL_SHORT_CYC(10),
    .FACTORY_KEY(FKEY), .FACTORY_PIN(FPIN), .FACTORY_ADDR(48'h0001),
    .FACTORY_MAN_ID(16'h0001)) rcc_config_i (.*);
  rcc_tool rcc_tool_i (.pin_i(pin_o), .try_i(try_pin), .unlock_o(protected_i));
  initial forever #2 mclk_i = ~mclk_i;
  task automatic end_sim;
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [127:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, c, input logic [7:0] a, d);
    int n;
    cfg_wr_i <= w;
    cfg_rd_i <= !w;
    cust_sel_i <= c;
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    @(posedge mclk_i);
    cfg_wr_i <= 1'b0;
    cfg_rd_i <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(negedge mclk_i);
      if (cfg_ack_o === 1'b1) break;
    end
    rdq = cfg_rdata_o;
    @(posedge mclk_i);
    if (n == 4) begin
      mismatches++;
      end_sim();
    end
  endtask
  task automatic rd(input logic c, input logic [7:0] a, e);
    acc(1'b0, c, a, 8'h00);
    chk("rdata", e, rdq);
  endtask
  function automatic logic [11:0] fq(input logic [7:0] c);
    if (c == 8'h25) return 12'h962;
    if (c == 8'h26) return 12'h97a;
    if (c == 8'h27) return 12'h9b0;
    if (c >= 8'h28) return 12'h963 + 2 * (c - 8'h28);
    return 12'h964 + 2 * c + (c > 8'h0a ? 12'h002 : 12'h000);
  endfunction
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    for (int a = 0; a < 4; a++) rd(1'b0, a[7:0], 8'h00);
    chk("interval", 20, interval_cyc_o);
    chk("rate", 0, rate_2m_o);
    acc(1'b1, 1'b0, 8'h00, 8'hf9);
    rd(1'b0, 8'h00, 8'h19);
    chk("interval", 10, interval_cyc_o);
    chk("rate", 1, rate_2m_o);
    acc(1'b1, 1'b0, 8'h01, 8'h25);
    acc(1'b1, 1'b0, 8'h02, 8'h28);
    acc(1'b1, 1'b0, 8'h03, 8'h4e);
    acc(1'b1, 1'b0, 8'h10, 8'hff);
    rd(1'b0, 8'h10, 8'h00);
    // Code seven is never written
    for (int m = 0; m < 7; m++) begin
      acc(1'b1, 1'b0, 8'h00, m[7:0]);
      repeat (2) @(posedge mclk_i);
      chk("count", m == 0 ? 0 : m < 4 ? 4 - m : 7 - m, chan_count_o);
      chk("advc", m < 4, adv_commission_o);
      chk("advd", m == 0, adv_data_o);
      chk("code0", m == 0 ? 0 : 8'h25, chan_code0_o);
      chk("code2", m == 1 || m == 4 ? 8'h4e : 0, chan_code2_o);
      chk("code1", m == 3 || m == 6 || m == 0 ? 0 : 8'h28, chan_code1_o);
    end
    acc(1'b1, 1'b0, 8'h00, 8'h04);
    repeat (2) @(posedge mclk_i);
    chk("freq1", 12'h963, freq1_mhz_o);
    chk("freq2", 12'h9af, freq2_mhz_o);
    foreach (codes[i]) begin
      acc(1'b1, 1'b0, 8'h01, codes[i]);
      repeat (2) @(posedge mclk_i);
      chk("freq0", fq(codes[i]), freq0_mhz_o);
    end
    try_pin <= FPIN;
    acc(1'b1, 1'b1, 8'h05, 8'ha5);
    try_pin <= 32'h0000;
    rd(1'b1, 8'h05, 8'h00);
    acc(1'b1, 1'b1, 8'h05, 8'h5a);
    {key_load_i, addr_load_i, man_load_i, pin_load_i} <= 4'hf;
    @(posedge mclk_i);
    {key_load_i, addr_load_i, man_load_i, pin_load_i} <= 4'h0;
    repeat (2) @(posedge mclk_i);
    chk("key", key_new_i, key_o);
    chk("pin", pin_new_i, pin_o);
    factory_reset_i <= 1'b1;
    @(posedge mclk_i);
    factory_reset_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk("key", FKEY, key_o);
    chk("addr", 48'h0001, source_addr_o);
    chk("man", 16'h0001, man_id_o);
    chk("pin", FPIN, pin_o);
    try_pin <= FPIN;
    @(posedge mclk_i);
    rd(1'b1, 8'h05, 8'ha5);
    end_sim();
  end
endmodule
`default_nettype wire
